// ---- src/scw_bank.sv ----
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module scw_bank #(
	parameter logic [2:0] REVISION_ID = 3'h5 // arbitrary value
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [18:0] loop_filter_setting_o,
	output logic [3:0] pump_current_select_o,
	output logic [5:0] vco_cal_value_o,
	output logic vco_cal_override_o,
	output logic vco_cal_enable_o,
	output logic [3:0] factory_test_config_o
);
	logic [18:0] lf_reg, lf_next;
	logic [3:0] pump_reg, pump_next;
	logic [5:0] cal_reg, cal_next;
	logic ovr_reg, ovr_next, en_reg, en_next;
	logic [3:0] test_reg, test_next;
	logic tbit_reg, tbit_next;
	logic err_reg, err_next;
	logic [2:0] last_sel_reg, last_sel_next;
	logic ack_reg, ack_next;
	logic [31:0] rd_reg, rd_next;
	logic [10:0] w;
	logic [2:0] sel;
	logic [7:0] pay;
	logic take;
	logic word_wr;
	logic wait_reg, wait_next;

	assign w = avs_writedata_i[scw_pkg::WORD_W-1:0];
	assign sel = w[scw_pkg::SEL_MSB:scw_pkg::SEL_LSB];
	assign pay = w[scw_pkg::PAY_MSB:scw_pkg::PAY_LSB];
	// taken only while no answer is pending, so each access counts once
	assign take = (avs_read_i || avs_write_i) && !ack_reg;
	assign word_wr = take && avs_write_i && avs_address_i == scw_pkg::ADDR_WORD;

	// one wait state per access keeps read data registered
	always_comb begin
		lf_next = lf_reg;
		pump_next = pump_reg;
		cal_next = cal_reg;
		ovr_next = ovr_reg;
		en_next = en_reg;
		test_next = test_reg;
		tbit_next = tbit_reg;
		err_next = err_reg;
		last_sel_next = last_sel_reg;
		rd_next = rd_reg;
		ack_next = 1'b0;
		if (take) begin
			ack_next = 1'b1;
			rd_next = 32'h0;
			if (avs_write_i && avs_address_i == scw_pkg::ADDR_WORD) begin
				last_sel_next = sel;
				case (sel)
					scw_pkg::SEL_LF_LOW: begin
						lf_next[scw_pkg::LF_LOW_MSB:scw_pkg::LF_LOW_LSB] = pay;
					end
					scw_pkg::SEL_LF_MID: begin
						lf_next[scw_pkg::LF_MID_MSB:scw_pkg::LF_MID_LSB] = pay;
					end
					scw_pkg::SEL_LF_PUMP: begin
						lf_next[scw_pkg::LF_TOP_MSB:scw_pkg::LF_TOP_LSB] =
							w[scw_pkg::LF_HI_MSB:scw_pkg::PAY_LSB];
						pump_next = w[scw_pkg::PUMP_MSB:scw_pkg::PUMP_LSB];
						tbit_next = w[scw_pkg::TEST_BIT];
						err_next = err_reg | w[scw_pkg::TEST_BIT];
					end
					scw_pkg::SEL_VCO_CAL: begin
						cal_next = w[scw_pkg::CAL_MSB:scw_pkg::PAY_LSB];
						ovr_next = w[scw_pkg::CAL_OVR_BIT];
						en_next = w[scw_pkg::CAL_EN_BIT];
					end
					scw_pkg::SEL_TEST: begin
						test_next = w[scw_pkg::TEST_CFG_MSB:scw_pkg::PAY_LSB];
					end
					default: begin
						last_sel_next = sel; // other words belong elsewhere
					end
				endcase
			end else if (avs_read_i) begin
				case (avs_address_i)
					scw_pkg::ADDR_FILTER: rd_next = {9'h0, pump_reg, lf_reg};
					scw_pkg::ADDR_CAL: rd_next = {20'h0, test_reg, en_reg, ovr_reg, cal_reg};
					scw_pkg::ADDR_STATUS: rd_next = {24'h0, err_reg, tbit_reg, last_sel_reg,
						REVISION_ID};
					default: rd_next = 32'h0;
				endcase
			end
		end
		// registered so waitrequest leaves the block straight from a flop
		wait_next = ~ack_next;
	end

	// reset values alone give a working pll with no host present
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lf_reg <= scw_pkg::LF_RESET;
			pump_reg <= scw_pkg::PUMP_RESET;
			cal_reg <= scw_pkg::CAL_RESET;
			ovr_reg <= scw_pkg::CAL_OVR_RESET;
			en_reg <= scw_pkg::CAL_EN_RESET;
			test_reg <= scw_pkg::TEST_RESET;
			tbit_reg <= 1'b0;
			err_reg <= 1'b0;
			last_sel_reg <= scw_pkg::SEL_BITS_RESET;
			ack_reg <= 1'b0;
			wait_reg <= scw_pkg::WAIT_RESET;
			rd_reg <= 32'h0;
		end else begin
			lf_reg <= lf_next;
			pump_reg <= pump_next;
			cal_reg <= cal_next;
			ovr_reg <= ovr_next;
			en_reg <= en_next;
			test_reg <= test_next;
			tbit_reg <= tbit_next;
			err_reg <= err_next;
			last_sel_reg <= last_sel_next;
			ack_reg <= ack_next;
			wait_reg <= wait_next;
			rd_reg <= rd_next;
		end
	end

	assign avs_readdata_o = rd_reg;
	assign avs_waitrequest_o = wait_reg;
	assign loop_filter_setting_o = lf_reg;
	assign pump_current_select_o = pump_reg;
	assign vco_cal_value_o = cal_reg;
	assign vco_cal_override_o = ovr_reg;
	assign vco_cal_enable_o = en_reg;
	assign factory_test_config_o = test_reg;

	AST_MID: assert property (@(posedge clk_i) disable iff (rst_i)
		avs_write_i && !ack_reg && avs_address_i == scw_pkg::ADDR_WORD && sel == scw_pkg::SEL_LF_MID
		|=> lf_reg[15:8] == $past(w[10:3]) && lf_reg[7:0] == $past(lf_reg[7:0]))
		else $error("mid filter bits wrong");
	AST_HI: assert property (@(posedge clk_i) disable iff (rst_i)
		avs_write_i && !ack_reg && avs_address_i == scw_pkg::ADDR_WORD && sel == scw_pkg::SEL_LF_PUMP
		|=> lf_reg[18:16] == $past(w[5:3]))
		else $error("high filter bits wrong");
	AST_PUMP: assert property (@(posedge clk_i) disable iff (rst_i)
		avs_write_i && !ack_reg && avs_address_i == scw_pkg::ADDR_WORD && sel == scw_pkg::SEL_LF_PUMP
		|=> pump_current_select_o == $past(w[9:6]))
		else $error("pump select wrong");
	AST_CAL: assert property (@(posedge clk_i) disable iff (rst_i)
		avs_write_i && !ack_reg && avs_address_i == scw_pkg::ADDR_WORD && sel == scw_pkg::SEL_VCO_CAL
		|=> {vco_cal_enable_o, vco_cal_override_o, vco_cal_value_o} == $past(w[10:3]))
		else $error("cal word wrong");
	AST_ERR: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(err_reg) |-> $past(w[10]) && $past(sel) == scw_pkg::SEL_LF_PUMP)
		else $error("test bit flag without cause");
	AST_BOOT: assert property (@(posedge clk_i)
		$past(rst_i) |-> lf_reg == scw_pkg::LF_RESET && pump_reg == scw_pkg::PUMP_RESET
			&& en_reg && !ovr_reg)
		else $error("startup defaults wrong");
	AST_REV: assert property (@(posedge clk_i) disable iff (rst_i)
		avs_read_i && !ack_reg && avs_address_i == scw_pkg::ADDR_STATUS
		|=> !avs_waitrequest_o && avs_readdata_o[2:0] == REVISION_ID)
		else $error("revision id wrong");
	AST_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
		avs_write_i && !ack_reg && avs_address_i == scw_pkg::ADDR_WORD && sel == scw_pkg::SEL_LF_LOW
		|=> lf_reg[7:0] == $past(w[10:3]) && lf_reg[18:8] == $past(lf_reg[18:8]))
		else $error("low filter bits wrong");
	AST_TEST: assert property (@(posedge clk_i) disable iff (rst_i)
		avs_write_i && !ack_reg && avs_address_i == scw_pkg::ADDR_WORD && sel == scw_pkg::SEL_TEST
		|=> factory_test_config_o == $past(w[6:3]))
		else $error("test config wrong");

	// bus answer: one wait state, then a single low cycle
	AST_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> !avs_waitrequest_o)
		else $error("request not answered after one wait state");
	AST_WAIT_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	AST_RD_WORD: assert property (@(posedge clk_i) disable iff (rst_i)
		take && avs_read_i && avs_address_i == scw_pkg::ADDR_WORD |=> avs_readdata_o == 32'h0)
		else $error("word port read not zero");
	AST_RD_FILTER: assert property (@(posedge clk_i) disable iff (rst_i)
		take && avs_read_i && avs_address_i == scw_pkg::ADDR_FILTER
		|=> avs_readdata_o == {9'h0, pump_current_select_o, loop_filter_setting_o})
		else $error("filter read back wrong");
	AST_RD_CAL: assert property (@(posedge clk_i) disable iff (rst_i)
		take && avs_read_i && avs_address_i == scw_pkg::ADDR_CAL
		|=> avs_readdata_o == {20'h0, factory_test_config_o, vco_cal_enable_o,
			vco_cal_override_o, vco_cal_value_o})
		else $error("cal read back wrong");
	AST_REFUSED: assert property (@(posedge clk_i) disable iff (rst_i)
		take && avs_write_i && avs_address_i != scw_pkg::ADDR_WORD
		|=> $stable(lf_reg) && $stable(pump_reg) && $stable(cal_reg) && $stable(test_reg))
		else $error("write to read-only address changed a field");
	// unknown select codes touch no field, only the last-select record
	AST_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
		word_wr |=> last_sel_reg == $past(sel))
		else $error("last select not recorded");
	AST_TBIT: assert property (@(posedge clk_i) disable iff (rst_i)
		word_wr && sel == scw_pkg::SEL_LF_PUMP |=> tbit_reg == $past(w[scw_pkg::TEST_BIT]))
		else $error("reserved bit copy wrong");
	// sticky so a single bad pump word stays visible until reset
	AST_ERR_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		err_reg |=> err_reg)
		else $error("reserved bit flag cleared without reset");
	AST_HOLD_PUMP: assert property (@(posedge clk_i) disable iff (rst_i)
		!(word_wr && sel == scw_pkg::SEL_LF_PUMP) |=> $stable(pump_reg))
		else $error("pump select changed without its word");
	AST_HOLD_CAL: assert property (@(posedge clk_i) disable iff (rst_i)
		!(word_wr && sel == scw_pkg::SEL_VCO_CAL) |=> $stable({en_reg, ovr_reg, cal_reg}))
		else $error("cal fields changed without their word");
	AST_HOLD_TEST: assert property (@(posedge clk_i) disable iff (rst_i)
		!(word_wr && sel == scw_pkg::SEL_TEST) |=> $stable(test_reg))
		else $error("test config changed without its word");
	COV_WR: cover property (@(posedge clk_i) avs_write_i && !avs_waitrequest_o);
	COV_RD: cover property (@(posedge clk_i) avs_read_i && !avs_waitrequest_o);
	COV_ERR: cover property (@(posedge clk_i) $rose(err_reg));
	COV_PUMP: cover property (@(posedge clk_i) word_wr && sel == scw_pkg::SEL_LF_PUMP);
	COV_REFUSED: cover property (@(posedge clk_i)
		take && avs_write_i && avs_address_i != scw_pkg::ADDR_WORD);
endmodule

// ---- src/scw_pkg.sv ----
// Operation
// - select 010 word: filter bits 8..15
// - select 011 word: filter bits 16..18
// - pump current in bits 6..9, default ones
// - select 100 word: cal value, override, enable
// - boots alone with mandated reserved-bit defaults
// - fixed 3-bit revision id in status [2:0]
// - select 001 word: filter bits 0..7
package scw_pkg;
	localparam int WORD_W = 11;
	localparam logic [2:0] SEL_LF_LOW = 3'h1;
	localparam logic [2:0] SEL_LF_MID = 3'h2;
	localparam logic [2:0] SEL_LF_PUMP = 3'h3;
	localparam logic [2:0] SEL_VCO_CAL = 3'h4;
	localparam logic [2:0] SEL_TEST = 3'h5;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 2;
	localparam int PAY_LSB = 3;
	localparam int PAY_MSB = 10;
	localparam int PUMP_LSB = 6;
	localparam int PUMP_MSB = 9;
	localparam int LF_HI_MSB = 5;
	localparam int CAL_MSB = 8;
	localparam int CAL_OVR_BIT = 9;
	localparam int CAL_EN_BIT = 10;
	localparam int TEST_BIT = 10;
	localparam int TEST_CFG_MSB = 6;
	localparam int LF_LOW_LSB = 0;
	localparam int LF_LOW_MSB = 7;
	localparam int LF_MID_LSB = 8;
	localparam int LF_MID_MSB = 15;
	localparam int LF_TOP_LSB = 16;
	localparam int LF_TOP_MSB = 18;
	localparam logic WAIT_RESET = 1'b1;
	localparam logic [3:0] ADDR_WORD = 4'h0;
	localparam logic [3:0] ADDR_FILTER = 4'h4;
	localparam logic [3:0] ADDR_CAL = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hc;
	localparam logic [18:0] LF_RESET = 19'h0035f;
	localparam logic [3:0] PUMP_RESET = 4'hf;
	localparam logic [5:0] CAL_RESET = 6'h00;
	localparam logic CAL_EN_RESET = 1'b1;
	localparam logic CAL_OVR_RESET = 1'b0;
	localparam logic [3:0] TEST_RESET = 4'h0;
	localparam logic [2:0] SEL_BITS_RESET = 3'h0;
endpackage

// ---- sim/scw_host.sv ----
`timescale 1ns/1ps
module scw_host (
	input wire logic clk_i,
	input wire logic [31:0] readdata_i,
	input wire logic waitrequest_i,
	output logic [3:0] address_o,
	output logic read_o,
	output logic write_o,
	output logic [31:0] writedata_o
);
	initial begin
		address_o = 4'h0;
		read_o = 1'b0;
		write_o = 1'b0;
		writedata_o = 32'h0;
	end
	// held until waitrequest is seen low; on release address and data show the inverse, read and write go low
	task automatic xfer(input logic [3:0] a, input logic rd, input logic [31:0] d,
		output logic [31:0] q);
		address_o <= a;
		read_o <= rd;
		write_o <= !rd;
		writedata_o <= d;
		@(posedge clk_i);
		while (waitrequest_i !== 1'b0) begin
			@(posedge clk_i);
		end
		q = readdata_i;
		read_o <= 1'b0;
		write_o <= 1'b0;
		address_o <= ~a;
		writedata_o <= ~d;
		@(posedge clk_i);
	endtask
	task automatic send_word(input logic [2:0] s, input logic [7:0] p, output logic [10:0] w);
		logic [31:0] q;
		w = {p, s};
		if (s == 3'h3) w[10] = 1'b0;
		if (s == 3'h5) w[10:3] = 8'h00;
		xfer(4'h0, 1'b0, {21'h0, w}, q);
	endtask
endmodule

// ---- sim/synth_config_word_bank_tb_top.sv ----
`timescale 1ns/1ps
module synth_config_word_bank_tb_top;
	localparam logic [2:0] REV = 3'h6; // arbitrary value
	logic clk_i, rst_i, rd, wr, wait_n, ovr_o, en_o, ovr, en;
	logic [3:0] adr, pump_o, test_o, pump, test;
	logic [31:0] wdat, rdat, q;
	logic [18:0] lf_o, lf;
	logic [5:0] cal_o, cal;
	logic [10:0] w;
	logic err, tbit;
	logic [2:0] last_sel;
	logic [10:0] sent_q[$];
	int error_cnt, n_tests, seed;
	scw_bank #(.REVISION_ID(REV)) scw_bank_inst (.clk_i(clk_i), .rst_i(rst_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wait_n), .loop_filter_setting_o(lf_o),
		.pump_current_select_o(pump_o), .vco_cal_value_o(cal_o), .vco_cal_override_o(ovr_o),
		.vco_cal_enable_o(en_o), .factory_test_config_o(test_o));
	scw_host scw_host_inst (.clk_i(clk_i), .readdata_i(rdat), .waitrequest_i(wait_n),
		.address_o(adr), .read_o(rd), .write_o(wr), .writedata_o(wdat));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic model_reset();
		lf = scw_pkg::LF_RESET;
		pump = scw_pkg::PUMP_RESET;
		cal = scw_pkg::CAL_RESET;
		ovr = scw_pkg::CAL_OVR_RESET;
		en = scw_pkg::CAL_EN_RESET;
		test = scw_pkg::TEST_RESET;
		err = 1'b0;
		tbit = 1'b0;
		last_sel = scw_pkg::SEL_BITS_RESET;
		sent_q.delete();
	endtask
	task automatic model_apply();
		logic [10:0] word;
		while (sent_q.size() > 0) begin
			word = sent_q.pop_front();
			last_sel = word[2:0];
			case (word[2:0])
				3'h1: lf[7:0] = word[10:3];
				3'h2: lf[15:8] = word[10:3];
				3'h3: begin
					lf[18:16] = word[5:3];
					pump = word[9:6];
					tbit = word[10];
					err = err | word[10];
				end
				3'h4: {en, ovr, cal} = word[10:3];
				3'h5: test = word[6:3];
				default: ;
			endcase
		end
	endtask
	task automatic check_all();
		scw_host_inst.xfer(4'h4, 1'b1, 32'h0, q);
		check("filter_read", q, {9'h0, pump, lf});
		scw_host_inst.xfer(4'h8, 1'b1, 32'h0, q);
		check("cal_read", q, {20'h0, test, en, ovr, cal});
		scw_host_inst.xfer(4'hc, 1'b1, 32'h0, q);
		check("status_read", q, {24'h0, err, tbit, last_sel, REV});
		check("filter_out", {9'h0, pump_o, lf_o}, {9'h0, pump, lf});
		check("cal_out", {20'h0, test_o, en_o, ovr_o, cal_o},
			{20'h0, test, en, ovr, cal});
	endtask
	initial begin
		seed = 89;
		error_cnt = 0;
		n_tests = 0;
		rst_i = 1'b1;
		model_reset();
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		check_all();
		$display("test reset values done");
		for (int i = 0; i < 28; i++) begin
			scw_host_inst.send_word(3'($random(seed)), 8'($random(seed)), w);
			sent_q.push_back(w);
			model_apply();
			check_all();
		end
		$display("test random words done");
		scw_host_inst.xfer(4'h4, 1'b0, 32'h7ff, q);
		check_all();
		scw_host_inst.xfer(4'h0, 1'b1, 32'h0, q);
		check("word_port_read", q, 32'h0);
		scw_host_inst.xfer(4'h2, 1'b1, 32'h0, q);
		check("unmapped_read", q, 32'h0);
		$display("test refused accesses done");
		// deliberate breach of the reserved bit, to raise the sticky flag
		scw_host_inst.xfer(4'h0, 1'b0, 32'h5a3, q);
		sent_q.push_back(11'h5a3);
		model_apply();
		check_all();
		scw_host_inst.send_word(3'h3, 8'($random(seed)), w);
		sent_q.push_back(w);
		model_apply();
		check_all();
		$display("test reserved bit flag done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		model_reset();
		check_all();
		$display("test second reset done");
		final_report();
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		error_cnt++;
		final_report();
	end
endmodule
